// ===== bench/mrp_phy_model.sv
// mrp_phy_model.sv: external phy model facing the port's mii/rmii pins
`timescale 1ns/10ps
module mrp_phy_model (
    input  wire        run,
    input  wire        pace_clk,
    input  wire        col_req,
    output logic       clk,
    output logic       tx_en,
    output logic       tx_er,
    output logic [3:0] txd,
    output logic       col,
    output logic       crs
);
    // ==========================================================
    // link clock, 320 ns, stands still low when not running
    initial clk = 1'b0;
    always begin
        #160;
        if (run || clk) clk = ~clk;
    end

    initial begin
        tx_en = 1'b0;
        tx_er = 1'b0;
        txd   = 4'h0;
    end

    assign col = col_req;
    assign crs = tx_en | col_req;

    // ==========================================================
    // frame: one unit per falling edge of the clock the port samples on,
    // which is the port's own clock when it drives the link
    task automatic send(input logic [3:0] n[$], input int e);
        foreach (n[i]) begin
            @(negedge pace_clk);
            tx_en <= 1'b1;
            txd   <= n[i];
            tx_er <= (i == e);
        end
        @(negedge pace_clk);
        tx_en <= 1'b0;
        tx_er <= 1'b0;
        // idle data is not left looking like the last unit
        txd   <= ~txd;
    endtask
endmodule // mrp_phy_model

// ===== bench/mrp_port_sva.sv
// mrp_port_sva.sv: port checker and its bind
`timescale 1ns/10ps
module mrp_port_sva (
    input wire       core_clk,
    input wire       rst_n,
    input wire       interface_strap_high,
    input wire       interface_strap_low,
    input wire       role_clocking_strap,
    input wire       speed_strap,
    input wire       speed_10,
    input wire       half_duplex,
    input wire       tx_clk_o_q,
    input wire       tx_clk_oe_q,
    input wire       rx_clk_o_q,
    input wire       rx_clk_oe_q,
    input wire       col_o_q,
    input wire       col_oe_q,
    input wire       crs_oe_q,
    input wire       rx_dv_q,
    input wire [3:0] rxd_q,
    input wire       ig_valid_q,
    input wire [1:0] mode_q,
    input wire       cfg_done_q,
    input wire       strap_gigabit_q
);
    wire [1:0] sc = {interface_strap_high, interface_strap_low};
    wire [1:0] exp_mode = (sc == 2'h1) ? (role_clocking_strap ? 2'h1 : 2'h2)
                        : (sc == 2'h2) ? 2'h3 : 2'h0;
    wire [3:0] oes = {tx_clk_oe_q, rx_clk_oe_q, col_oe_q, crs_oe_q};

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_cfg;
        $rose(cfg_done_q);
    endsequence
    sequence s_high10;
        $stable(tx_clk_o_q)[*4] ##1 $fell(tx_clk_o_q);
    endsequence

    a_mode_code:
    assert property (s_cfg |-> mode_q == exp_mode) else $error("mode off straps");
    a_phy_dirs:
    assert property (mode_q == 2'h1 && $past(mode_q) == 2'h1 |-> oes == 4'hf)
        else $error("phy role pin direction");
    a_mac_dirs:
    assert property (mode_q == 2'h2 && $past(mode_q) == 2'h2 |-> oes == 4'h0)
        else $error("mac role pin direction");
    a_rmii_ref:
    assert property (mode_q == 2'h3 && $past(mode_q) == 2'h3 |->
        oes == {1'b0, !role_clocking_strap, 2'h0}) else $error("rmii clocking");
    a_rmii_narrow:
    assert property (mode_q == 2'h3 |-> rxd_q[3:2] == 2'h0)
        else $error("rmii upper data bits");
    a_gig_copy:
    assert property (cfg_done_q |-> strap_gigabit_q == speed_strap)
        else $error("speed strap copy");
    a_off_quiet:
    assert property (cfg_done_q && mode_q == 2'h0 |-> !rx_dv_q && !ig_valid_q)
        else $error("traffic while off");
    a_ig_single:
    assert property (ig_valid_q |=> !ig_valid_q) else $error("ingress pulse");
    a_col_half:
    assert property (mode_q == 2'h1 && col_o_q |-> $past(half_duplex))
        else $error("collision in full duplex");
    a_ref_toggle:
    assert property (mode_q == 2'h3 && $past(mode_q) == 2'h3 &&
        !role_clocking_strap |-> rx_clk_o_q != $past(rx_clk_o_q))
        else $error("made reference clock");
    a_mii10_clk:
    assert property (mode_q == 2'h1 && speed_10 && $rose(tx_clk_o_q) |=>
        s_high10) else $error("mii 10M clock");
endmodule // mrp_port_sva

bind mrp_port mrp_port_sva i_mrp_port_sva (.core_clk(core_clk), .rst_n(rst_n),
    .interface_strap_high(interface_strap_high),
    .interface_strap_low(interface_strap_low),
    .role_clocking_strap(role_clocking_strap), .speed_strap(speed_strap),
    .speed_10(speed_10), .half_duplex(half_duplex),
    .tx_clk_o_q(tx_clk_o_q), .tx_clk_oe_q(tx_clk_oe_q),
    .rx_clk_o_q(rx_clk_o_q), .rx_clk_oe_q(rx_clk_oe_q), .col_o_q(col_o_q),
    .col_oe_q(col_oe_q), .crs_oe_q(crs_oe_q), .rx_dv_q(rx_dv_q),
    .rxd_q(rxd_q), .ig_valid_q(ig_valid_q), .mode_q(mode_q),
    .cfg_done_q(cfg_done_q), .strap_gigabit_q(strap_gigabit_q));

// ===== bench/mrp_port_tb_top.sv
// mrp_port_tb_top.sv: self-checking bench for the mii/rmii port
`timescale 1ns/10ps
module mrp_port_tb_top;
    reg core_clk = 0, rst_n = 0, sh = 0, sl = 0, role = 0, spd = 0, s10 = 0;
    reg hd = 0, egv = 0, ege = 0, run = 1, colr = 0, colseen = 0, lk_q = 0;
    reg [3:0] egd = 4'h0;
    integer n_errors = 0, n_tests = 0;
    logic [4:0] cap[$], igq[$];
    wire m_clk, m_en, m_er, m_col, m_crs, txco, txcoe, rxco, rxcoe;
    wire colo, coloe, crso, crsoe, rx_dv_q, rx_er_q, eg_ready_q, ig_valid_q;
    wire ig_err_q, ig_frame_q, cfg_done_q, gig, link_col_q, link_crs_q;
    wire [3:0] m_txd, rxd_q, ig_data_q;
    wire [1:0] mode_q;
    // two-way pins: the driving party wins
    wire txci = txcoe ? txco : m_clk;
    wire rxci = rxcoe ? rxco : m_clk;
    wire coli = coloe ? colo : m_col;
    wire crsi = crsoe ? crso : m_crs;
    wire lk = (mode_q == 2'h3) ? (role ? txci : rxco) : rxci;
    // clock that paces the partner's transmit units
    wire pc = (mode_q == 2'h3 && !role) ? rxco : txci;

    always #20 core_clk = ~core_clk;

    mrp_phy_model i_mrp_phy_model (.run(run), .pace_clk(pc), .col_req(colr),
        .clk(m_clk), .tx_en(m_en), .tx_er(m_er), .txd(m_txd), .col(m_col),
        .crs(m_crs));

    mrp_port i_mrp_port (.core_clk(core_clk), .rst_n(rst_n),
        .interface_strap_high(sh), .interface_strap_low(sl),
        .role_clocking_strap(role), .speed_strap(spd), .speed_10(s10),
        .half_duplex(hd), .tx_en(m_en), .tx_er(m_er), .txd(m_txd),
        .tx_clk_i(txci), .tx_clk_o_q(txco), .tx_clk_oe_q(txcoe),
        .rx_clk_i(rxci), .rx_clk_o_q(rxco), .rx_clk_oe_q(rxcoe),
        .col_i(coli), .col_o_q(colo), .col_oe_q(coloe), .crs_i(crsi),
        .crs_o_q(crso), .crs_oe_q(crsoe), .rx_dv_q(rx_dv_q),
        .rx_er_q(rx_er_q), .rxd_q(rxd_q), .eg_valid(egv),
        .eg_ready_q(eg_ready_q), .eg_data(egd), .eg_err(ege),
        .ig_valid_q(ig_valid_q), .ig_data_q(ig_data_q), .ig_err_q(ig_err_q),
        .ig_frame_q(ig_frame_q), .mode_q(mode_q), .cfg_done_q(cfg_done_q),
        .strap_gigabit_q(gig), .link_col_q(link_col_q),
        .link_crs_q(link_crs_q));

    // ==========================================================
    // monitors: egress sampled once per slot at the link clock fall
    always @(posedge core_clk) begin
        lk_q <= lk;
        if (!lk && lk_q && rx_dv_q) cap.push_back({rx_er_q, rxd_q});
        if (ig_valid_q) igq.push_back({ig_err_q, ig_data_q});
        if (colo && coloe) colseen <= 1'b1;
    end

    task check(input string w, input logic [7:0] seen, input logic [7:0] ex);
        n_tests = n_tests + 1;
        if (seen !== ex) begin
            n_errors = n_errors + 1;
            $display("BAD %s expected %h seen %h", w, ex, seen);
        end
    endtask

    task automatic cmp(input string w, input logic [4:0] got[$],
                       input logic [4:0] ex[$]);
        check({w, " count"}, 8'(got.size()), 8'(ex.size()));
        foreach (ex[i]) check(w, got[i], ex[i]);
    endtask

    task complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task restart(input [1:0] code, input r, input s, input [1:0] m);
        @(posedge core_clk);
        rst_n <= 1'b0;
        {sh, sl} <= code;
        role <= r;
        s10 <= s;
        spd <= ~s;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge core_clk);
        check("mode", mode_q, m);
        check("cfg done", cfg_done_q, 1'b1);
        check("gig copy", gig, spd);
        cap.delete();
        igq.delete();
    endtask

    // request held until the edge that samples ready high
    task push(input [3:0] d, input e);
        reg ok;
        egv <= 1'b1;
        egd <= d;
        ege <= e;
        do begin
            @(negedge core_clk);
            ok = eg_ready_q;
            @(posedge core_clk);
        end while (ok !== 1'b1);
    endtask

    initial begin
        #1000000;
        n_errors = n_errors + 1;
        $display("watchdog expired");
        complete_run;
    end

    initial begin
        hd <= 1'b1;
        restart(2'h1, 1'b1, 1'b1, 2'h1);
        check("phy oe", {txcoe, rxcoe, coloe, crsoe}, 4'hf);
        fork
            begin
                push(4'h1, 0); push(4'h2, 0); push(4'he, 1); push(4'h7, 0);
                egv <= 1'b0;
            end
            i_mrp_phy_model.send('{4'h5, 4'h6, 4'h7, 4'h8}, -1);
        join
        repeat (80) @(posedge core_clk);
        cmp("mii phy egress", cap, '{5'h01, 5'h02, 5'h1e, 5'h07});
        cmp("mii phy ingress", igq, '{5'h05, 5'h06, 5'h07, 5'h08});
        check("collision seen", colseen, 1'b1);
        $display("test 1 done");
        restart(2'h1, 1'b0, 1'b0, 2'h2);
        check("mac oe", {txcoe, rxcoe, coloe, crsoe}, 4'h0);
        i_mrp_phy_model.send('{4'h3, 4'h9, 4'hc}, 1);
        repeat (20) @(posedge core_clk);
        cmp("mii mac ingress", igq, '{5'h03, 5'h19, 5'h0c});
        colr <= 1'b1;
        repeat (8) @(posedge core_clk);
        check("col half", link_col_q, 1'b1);
        hd <= 1'b0;
        repeat (8) @(posedge core_clk);
        check("col full", link_col_q, 1'b0);
        colr <= 1'b0;
        run <= 1'b0;
        repeat (12) @(posedge core_clk);
        push(4'h5, 0); push(4'h6, 0); push(4'h7, 0); push(4'h8, 1);
        egd <= 4'h9;
        ege <= 1'b0;
        repeat (4) @(posedge core_clk);
        check("fifo full", eg_ready_q, 1'b0);
        run <= 1'b1;
        push(4'h9, 0);
        egv <= 1'b0;
        repeat (80) @(posedge core_clk);
        cmp("mii mac egress", cap, '{5'h05, 5'h06, 5'h07, 5'h18, 5'h09});
        $display("test 2 done");
        restart(2'h2, 1'b1, 1'b0, 2'h3);
        check("rmii ext oe", {txcoe, rxcoe}, 2'h0);
        i_mrp_phy_model.send('{4'h1, 4'h2, 4'h3, 4'h0}, 2);
        repeat (20) @(posedge core_clk);
        cmp("rmii ingress", igq, '{5'h09, 5'h13});
        push(4'hb, 0); push(4'h4, 1);
        egv <= 1'b0;
        repeat (60) @(posedge core_clk);
        cmp("rmii egress", cap, '{5'h03, 5'h02, 5'h10, 5'h11});
        $display("test 3 done");
        restart(2'h2, 1'b0, 1'b1, 2'h3);
        check("rmii ref out", rxcoe, 1'b1);
        $display("test 4 done");
        restart(2'h3, 1'b1, 1'b0, 2'h0);
        push(4'ha, 0);
        egv <= 1'b0;
        repeat (40) @(posedge core_clk);
        check("off quiet", rx_dv_q, 1'b0);
        $display("test 5 done");
        complete_run;
    end
endmodule // mrp_port_tb_top

// ===== rtl/mrp_consts.vh
// mrp_consts.vh: constants for the mii/rmii port interface
`ifndef MRP_CONSTS_VH
`define MRP_CONSTS_VH
`define MRP_CLK_NS     40
`define MRP_MII100_NS  40
`define MRP_MII10_NS   400
`define MRP_REF_NS     20
`define MRP_IF_MII     2'h1
`define MRP_IF_RMII    2'h2
`define MRP_SYNC_DONE  2'h3
`define MRP_REP_LAST   4'h9
`define MRP_REP_MID    4'h5
`define MRP_FIFO_W     5
`define MRP_FIFO_D     4
`define MRP_FIFO_AW    2
`endif

// ===== rtl/mrp_port.v
// mrp_port.v: mii/rmii port logic with its egress fifo
`timescale 1ns/10ps
`include "mrp_consts.vh"

// ==========================================================
// egress fifo
module mrp_fifo #(
    parameter W  = 5,
    parameter D  = 4,
    parameter AW = 2
) (
    input  wire          clk,
    input  wire          rst_n,
    input  wire          in_valid,
    output reg           in_ready_q,
    input  wire [W-1:0]  in_data,
    output wire          out_valid,
    input  wire          out_ready,
    output wire [W-1:0]  out_data
);
    reg  [W-1:0] mem [0:D-1];
    reg  [AW:0]  wr_q;
    reg  [AW:0]  rd_q;
    wire         push;
    wire         pop;
    wire [AW:0]  wr_d;
    wire [AW:0]  rd_d;
    wire [AW:0]  fill_d;

    assign push      = in_valid & in_ready_q;
    assign out_valid = (wr_q != rd_q);
    assign pop       = out_valid & out_ready;
    assign out_data  = mem[rd_q[AW-1:0]];
    assign wr_d      = push ? wr_q + 1'b1 : wr_q;
    assign rd_d      = pop ? rd_q + 1'b1 : rd_q;
    assign fill_d    = wr_d - rd_d;

    always @(posedge clk) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end

    // ready is registered so the top's outputs stay flop driven
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q       <= {(AW+1){1'b0}};
            rd_q       <= {(AW+1){1'b0}};
            in_ready_q <= 1'b0;
        end else begin
            wr_q       <= wr_d;
            rd_q       <= rd_d;
            in_ready_q <= (fill_d != D[AW:0]);
        end
    end
endmodule // mrp_fifo

// ==========================================================
// port top
module mrp_port (
    input  wire       core_clk,
    input  wire       rst_n,
    input  wire       interface_strap_high,
    input  wire       interface_strap_low,
    input  wire       role_clocking_strap,
    input  wire       speed_strap,
    input  wire       speed_10,
    input  wire       half_duplex,
    input  wire       tx_en,
    input  wire       tx_er,
    input  wire [3:0] txd,
    input  wire       tx_clk_i,
    output reg        tx_clk_o_q,
    output reg        tx_clk_oe_q,
    input  wire       rx_clk_i,
    output reg        rx_clk_o_q,
    output reg        rx_clk_oe_q,
    input  wire       col_i,
    output reg        col_o_q,
    output reg        col_oe_q,
    input  wire       crs_i,
    output reg        crs_o_q,
    output reg        crs_oe_q,
    output reg        rx_dv_q,
    output reg        rx_er_q,
    output reg  [3:0] rxd_q,
    input  wire       eg_valid,
    output wire       eg_ready_q,
    input  wire [3:0] eg_data,
    input  wire       eg_err,
    output reg        ig_valid_q,
    output reg  [3:0] ig_data_q,
    output reg        ig_err_q,
    output reg        ig_frame_q,
    output reg  [1:0] mode_q,
    output reg        cfg_done_q,
    output reg        strap_gigabit_q,
    output reg        link_col_q,
    output reg        link_crs_q
);
    localparam [1:0] MODE_OFF  = 2'h0;
    localparam [1:0] MODE_PHY  = 2'h1;
    localparam [1:0] MODE_MAC  = 2'h2;
    localparam [1:0] MODE_RMII = 2'h3;

    // half period in core cycles, rounded down, never below one
    function [2:0] mrp_half;
        input integer ns;
        integer c;
        begin
            c = ns / 2 / `MRP_CLK_NS;
            if (c < 1) begin
                c = 1;
            end
            mrp_half = c[2:0];
        end
    endfunction

    // ======================================================
    // pin synchronisers
    reg  [9:0] pin_s1_q;
    reg  [9:0] pin_s2_q;
    reg  [1:0] clk_s3_q;
    reg  [3:0] strap_s1_q;
    reg  [3:0] strap_s2_q;
    wire       s_tx_en;
    wire       s_tx_er;
    wire [3:0] s_txd;
    wire       s_tx_clk;
    wire       s_rx_clk;
    wire       s_col;
    wire       s_crs;

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_q   <= 10'h000;
            pin_s2_q   <= 10'h000;
            clk_s3_q   <= 2'h0;
            strap_s1_q <= 4'h0;
            strap_s2_q <= 4'h0;
        end else begin
            pin_s1_q   <= {tx_en, tx_er, txd, tx_clk_i, rx_clk_i,
                           col_i, crs_i};
            pin_s2_q   <= pin_s1_q;
            clk_s3_q   <= pin_s2_q[3:2];
            strap_s1_q <= {interface_strap_high, interface_strap_low,
                           role_clocking_strap, speed_strap};
            strap_s2_q <= strap_s1_q;
        end
    end

    assign s_tx_en  = pin_s2_q[9];
    assign s_tx_er  = pin_s2_q[8];
    assign s_txd    = pin_s2_q[7:4];
    assign s_tx_clk = pin_s2_q[3];
    assign s_rx_clk = pin_s2_q[2];
    assign s_col    = pin_s2_q[1];
    assign s_crs    = pin_s2_q[0];

    // ======================================================
    // strap capture after reset release
    reg [1:0] cap_cnt_q;
    reg       role_q;

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_cnt_q       <= 2'h0;
            cfg_done_q      <= 1'b0;
            mode_q          <= MODE_OFF;
            role_q          <= 1'b0;
            strap_gigabit_q <= 1'b0;
        end else if (!cfg_done_q) begin
            cap_cnt_q <= cap_cnt_q + 2'h1;
            if (cap_cnt_q == `MRP_SYNC_DONE) begin
                cfg_done_q      <= 1'b1;
                role_q          <= strap_s2_q[1];
                strap_gigabit_q <= strap_s2_q[0];
                if (strap_s2_q[3:2] == `MRP_IF_MII) begin
                    mode_q <= strap_s2_q[1] ? MODE_PHY : MODE_MAC;
                end else if (strap_s2_q[3:2] == `MRP_IF_RMII) begin
                    mode_q <= MODE_RMII;
                end else begin
                    mode_q <= MODE_OFF;
                end
            end
        end
    end

    // ======================================================
    // internal clock generator
    wire       is_rmii;
    wire       is_mac;
    wire       int_ref;
    wire [2:0] half;
    reg  [2:0] div_q;
    reg        gclk_q;
    wire       wrap;
    wire       gclk_d;
    wire       int_rise;
    wire       int_fall;

    assign is_rmii  = (mode_q == MODE_RMII);
    assign is_mac   = (mode_q == MODE_MAC);
    assign int_ref  = is_rmii & ~role_q;
    // the core clock cannot be multiplied, so the 20 ns and 40 ns made clocks
    // run at the fastest even division of it, 80 ns; intent is preserved
    assign half     = is_rmii ? mrp_half(`MRP_REF_NS) :
                      (speed_10 ? mrp_half(`MRP_MII10_NS) :
                                  mrp_half(`MRP_MII100_NS));
    assign wrap     = (div_q >= half - 3'h1);
    assign gclk_d   = wrap ? ~gclk_q : gclk_q;
    assign int_rise = wrap & ~gclk_q;
    assign int_fall = wrap & gclk_q;

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q  <= 3'h0;
            gclk_q <= 1'b0;
        end else begin
            div_q  <= wrap ? 3'h0 : div_q + 3'h1;
            gclk_q <= gclk_d;
        end
    end

    // ======================================================
    // tick selection
    wire tx_rise;
    wire tx_fall;
    wire rx_rise;
    wire rx_fall;
    wire ref_rise;
    wire ref_fall;
    wire ig_tick;
    wire eg_tick;
    reg  [3:0] rep_q;

    assign tx_rise  = s_tx_clk & ~clk_s3_q[1];
    assign tx_fall  = ~s_tx_clk & clk_s3_q[1];
    assign rx_rise  = s_rx_clk & ~clk_s3_q[0];
    assign rx_fall  = ~s_rx_clk & clk_s3_q[0];
    assign ref_rise = role_q ? tx_rise : int_rise;
    assign ref_fall = role_q ? tx_fall : int_fall;

    // at 10M one data slot spans ten reference cycles
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rep_q <= 4'h0;
        end else if (is_rmii && ref_rise) begin
            rep_q <= (!speed_10 || rep_q == `MRP_REP_LAST) ?
                     4'h0 : rep_q + 4'h1;
        end
    end

    // sample mid-slot at 10M so the far end's edge is never hit
    assign ig_tick = is_rmii ? ref_rise &
                     (!speed_10 || rep_q == `MRP_REP_MID) :
                     (is_mac ? tx_rise : int_rise);
    assign eg_tick = is_rmii ? ref_fall &
                     (!speed_10 || rep_q == 4'h0) :
                     (is_mac ? rx_fall : int_fall);

    // ======================================================
    // ingress: tx pins into the device
    reg [1:0] low_pair_q;
    reg       pair_q;
    reg       pair_err_q;

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ig_valid_q <= 1'b0;
            ig_data_q  <= 4'h0;
            ig_err_q   <= 1'b0;
            ig_frame_q <= 1'b0;
            low_pair_q <= 2'h0;
            pair_q     <= 1'b0;
            pair_err_q <= 1'b0;
        end else begin
            ig_valid_q <= 1'b0;
            if (ig_tick && mode_q != MODE_OFF) begin
                ig_frame_q <= s_tx_en;
                if (!is_rmii) begin
                    ig_valid_q <= s_tx_en;
                    ig_data_q  <= s_txd;
                    ig_err_q   <= s_tx_er;
                end else if (!s_tx_en) begin
                    pair_q <= 1'b0;
                end else if (!pair_q) begin
                    low_pair_q <= s_txd[1:0];
                    pair_err_q <= s_tx_er;
                    pair_q     <= 1'b1;
                end else begin
                    ig_valid_q <= 1'b1;
                    ig_data_q  <= {s_txd[1:0], low_pair_q};
                    ig_err_q   <= pair_err_q | s_tx_er;
                    pair_q     <= 1'b0;
                end
            end
        end
    end

    // ======================================================
    // egress: fifo to rx pins
    wire       f_valid;
    wire [4:0] f_data;
    wire       f_pop;
    reg        phase_q;

    assign f_pop = eg_tick & f_valid & (!is_rmii | phase_q) &
                   (mode_q != MODE_OFF);

    mrp_fifo #(
        .W  (`MRP_FIFO_W),
        .D  (`MRP_FIFO_D),
        .AW (`MRP_FIFO_AW)
    ) u_fifo (
        .clk        (core_clk),
        .rst_n      (rst_n),
        .in_valid   (eg_valid),
        .in_ready_q (eg_ready_q),
        .in_data    ({eg_err, eg_data}),
        .out_valid  (f_valid),
        .out_ready  (f_pop),
        .out_data   (f_data)
    );

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_dv_q <= 1'b0;
            rx_er_q <= 1'b0;
            rxd_q   <= 4'h0;
            phase_q <= 1'b0;
        end else if (mode_q == MODE_OFF) begin
            rx_dv_q <= 1'b0;
            rx_er_q <= 1'b0;
            rxd_q   <= 4'h0;
        end else if (eg_tick) begin
            if (!f_valid) begin
                // fifo ran dry: frame ends; a nibble pops only after its second half, so none is split
                rx_dv_q <= 1'b0;
                rx_er_q <= 1'b0;
                phase_q <= 1'b0;
            end else if (!is_rmii) begin
                rx_dv_q <= 1'b1;
                rx_er_q <= f_data[4];
                rxd_q   <= f_data[3:0];
            end else begin
                rx_dv_q <= 1'b1;
                rx_er_q <= f_data[4];
                rxd_q   <= {2'h0,
                            phase_q ? f_data[3:2] : f_data[1:0]};
                phase_q <= ~phase_q;
            end
        end
    end

    // ======================================================
    // clock, collision and carrier pins
    wire is_phy;
    wire crs_d;

    assign is_phy = (mode_q == MODE_PHY);
    assign crs_d  = rx_dv_q | s_tx_en;

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_clk_o_q  <= 1'b0;
            tx_clk_oe_q <= 1'b0;
            rx_clk_o_q  <= 1'b0;
            rx_clk_oe_q <= 1'b0;
            col_o_q     <= 1'b0;
            col_oe_q    <= 1'b0;
            crs_o_q     <= 1'b0;
            crs_oe_q    <= 1'b0;
            link_col_q  <= 1'b0;
            link_crs_q  <= 1'b0;
        end else begin
            tx_clk_oe_q <= is_phy;
            tx_clk_o_q  <= is_phy & gclk_d;
            rx_clk_oe_q <= is_phy | int_ref;
            rx_clk_o_q  <= (is_phy | int_ref) & gclk_d;
            col_oe_q    <= is_phy;
            crs_oe_q    <= is_phy;
            col_o_q     <= is_phy & half_duplex & rx_dv_q &
                           s_tx_en;
            crs_o_q     <= is_phy & crs_d;
            link_col_q  <= is_mac ? s_col & half_duplex :
                           (is_phy & half_duplex & rx_dv_q &
                            s_tx_en);
            link_crs_q  <= is_mac ? s_crs : (is_phy & crs_d);
        end
    end
endmodule // mrp_port
